// >>> logic/psd_dma.sv
// Two-channel descriptor-driven DMA engine between local SDRAM and PCI.
// Function
// - two channels, either direction, stop at list end
// - descriptors are four aligned Dwords, copied in
// - words: count/dir, PCI, SDRAM, next/upper address
// - SDRAM word bit 31 selects fourth word
// - select 0: fourth word is next pointer
// - select 0 with end flag: pointer loaded, unused
// - select 1: load upper address, next is +16
// - fetch descriptor unless control bit 4 set
// - count reaches zero sets done bit 2
// - end flag sets chain done bit 7, stops
// - any source and destination byte alignment
// - every read uses all byte enables
// - PCI read command from control bits 6:5
// - each byte moved decrements count, advances source
// - each byte moved advances destination; writes Dword aligned
// - first write masks lanes below destination offset
// - final write masks lanes above remainder
// - rotate lanes and pack into Dwords
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "psd_dma_regs.svh"

module psd_dma (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    output logic             mem_req_out,
    output logic             mem_we_out,
    output logic             mem_space_out,
    output logic      [31:0] mem_addr_out,
    output logic      [31:0] mem_addr_hi_out,
    output logic      [3:0]  mem_be_out,
    output logic      [1:0]  mem_cmd_out,
    output logic      [31:0] mem_wdata_out,
    input  wire logic        mem_ack_in,
    input  wire logic [31:0] mem_rdata_in
);

    psd_pkg::psd_q_t q_reg;
    psd_pkg::psd_q_t q_next;

    function automatic logic [31:0] psd_rd(input psd_pkg::psd_ch_t c,
                                           input logic [4:0] o);
        logic [31:0] r;
        r = `PSD_RESET_WORD;
        case (o)
            `PSD_OFF_CTRL: begin
                r[`PSD_CTRL_EN] = c.en;
                r[`PSD_CTRL_DONE] = c.done;
                r[`PSD_CTRL_INIT] = c.init;
                r[`PSD_CTRL_RT_HI:`PSD_CTRL_RT_LO] = c.rtype;
                r[`PSD_CTRL_CHDONE] = c.cdone;
            end
            `PSD_OFF_COUNT: begin
                r[`PSD_CNT_EOC] = c.eoc;
                r[`PSD_CNT_DIR] = c.dir;
                r[`PSD_CNT_MSB:0] = c.cnt;
            end
            `PSD_OFF_PCI:   r = c.pci;
            `PSD_OFF_SDRAM: r = c.sd;
            `PSD_OFF_PTR:   r = c.ptr;
            `PSD_OFF_DAC:   r = c.dac;
            default:        r = `PSD_RESET_WORD;
        endcase
        return r;
    endfunction : psd_rd

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        psd_pkg::psd_ch_t c;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] rd_a;
        logic [31:0] wa;
        logic [1:0]  so;
        logic [1:0]  doff;
        logic [3:0]  nbe;
        logic [31:0] npk;
        logic        go_rd;
        logic        go_fetch;
        logic        fin;
        logic        n;
        c = q_reg.ch[q_reg.cur];
        src = c.dir ? c.pci : {1'b0, c.sd[30:0]};
        dst = c.dir ? {1'b0, c.sd[30:0]} : c.pci;
        rd_a = {src[31:2], 2'b00};
        so = src[1:0];
        doff = dst[1:0];
        wa = q_reg.waddr;
        nbe = q_reg.pbe;
        npk = q_reg.pack;
        go_rd = 1'b0;
        go_fetch = 1'b0;
        fin = 1'b0;
        n = addr_in[5];
        q_next = q_reg;
        q_next.rdata = `PSD_RESET_WORD;

        // Software side of the register port.
        if (rd_in && addr_in[7:6] == 2'b00) begin
            q_next.rdata = psd_rd(q_reg.ch[n], addr_in[4:0]);
        end
        if (wr_in && addr_in[7:6] == 2'b00) begin
            case (addr_in[4:0])
                `PSD_OFF_CTRL: begin
                    q_next.ch[n].en = wdata_in[`PSD_CTRL_EN];
                    q_next.ch[n].init = wdata_in[`PSD_CTRL_INIT];
                    q_next.ch[n].rtype =
                        wdata_in[`PSD_CTRL_RT_HI:`PSD_CTRL_RT_LO];
                    if (wdata_in[`PSD_CTRL_DONE]) begin
                        q_next.ch[n].done = 1'b0;
                    end
                    if (wdata_in[`PSD_CTRL_CHDONE]) begin
                        q_next.ch[n].cdone = 1'b0;
                    end
                end
                `PSD_OFF_COUNT: begin
                    q_next.ch[n].eoc = wdata_in[`PSD_CNT_EOC];
                    q_next.ch[n].dir = wdata_in[`PSD_CNT_DIR];
                    q_next.ch[n].cnt = wdata_in[`PSD_CNT_MSB:0];
                end
                `PSD_OFF_PCI:   q_next.ch[n].pci = wdata_in;
                `PSD_OFF_SDRAM: q_next.ch[n].sd = wdata_in;
                `PSD_OFF_PTR:   q_next.ch[n].ptr = wdata_in;
                `PSD_OFF_DAC:   q_next.ch[n].dac = wdata_in;
                default: ;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Engine: one channel at a time, the other waits its turn.
        unique case (q_reg.st)
            psd_pkg::PSD_IDLE: begin
                if (c.en) begin
                    if (c.init) begin
                        if (c.cnt == 24'h00_0000) begin
                            fin = 1'b1;
                        end else begin
                            go_rd = 1'b1;
                        end
                    end else begin
                        q_next.desc = c.ptr;
                        q_next.idx = 2'b00;
                        go_fetch = 1'b1;
                    end
                end else begin
                    q_next.cur = ~q_reg.cur;
                end
            end
            psd_pkg::PSD_FETCH: begin
                if (q_reg.req && mem_ack_in) begin
                    q_next.req = 1'b0;
                    unique case (q_reg.idx)
                        2'b00: begin
                            q_next.ch[q_reg.cur].eoc =
                                mem_rdata_in[`PSD_CNT_EOC];
                            q_next.ch[q_reg.cur].dir =
                                mem_rdata_in[`PSD_CNT_DIR];
                            q_next.ch[q_reg.cur].cnt =
                                mem_rdata_in[`PSD_CNT_MSB:0];
                        end
                        2'b01: q_next.ch[q_reg.cur].pci = mem_rdata_in;
                        2'b10: q_next.ch[q_reg.cur].sd = mem_rdata_in;
                        2'b11: begin
                            if (c.sd[`PSD_MODE_BIT]) begin
                                q_next.ch[q_reg.cur].dac = mem_rdata_in;
                                q_next.ch[q_reg.cur].ptr =
                                    q_reg.desc + `PSD_DESC_STEP;
                            end else begin
                                q_next.ch[q_reg.cur].ptr = mem_rdata_in;
                            end
                        end
                    endcase
                    if (q_reg.idx == 2'b11) begin
                        if (c.cnt == 24'h00_0000) begin
                            fin = 1'b1;
                        end else begin
                            go_rd = 1'b1;
                        end
                    end else begin
                        q_next.idx = q_reg.idx + 2'b01;
                        go_fetch = 1'b1;
                    end
                end
            end
            psd_pkg::PSD_RD: begin
                if (q_reg.req && mem_ack_in) begin
                    q_next.req = 1'b0;
                    q_next.word = mem_rdata_in;
                    q_next.st = psd_pkg::PSD_SHIFT;
                end
            end
            psd_pkg::PSD_SHIFT: begin
                // Byte lanes rotate by the source/destination offset.
                npk[8*doff +: 8] = q_reg.word[8*so +: 8];
                nbe[doff] = 1'b1;
                if (q_reg.pbe == 4'h0) begin
                    wa = {dst[31:2], 2'b00};
                end
                q_next.pack = npk;
                q_next.pbe = nbe;
                q_next.waddr = wa;
                q_next.ch[q_reg.cur].cnt = c.cnt - 24'h00_0001;
                if (c.dir) begin
                    q_next.ch[q_reg.cur].pci = c.pci + 32'h0000_0001;
                    q_next.ch[q_reg.cur].sd =
                        {c.sd[31], c.sd[30:0] + 31'h0000_0001};
                end else begin
                    q_next.ch[q_reg.cur].sd =
                        {c.sd[31], c.sd[30:0] + 31'h0000_0001};
                    q_next.ch[q_reg.cur].pci = c.pci + 32'h0000_0001;
                end
                if (doff == 2'b11 || c.cnt == 24'h00_0001) begin
                    q_next.req = 1'b1;
                    q_next.we = 1'b1;
                    q_next.space = ~c.dir;
                    q_next.addr = wa;
                    q_next.addr_hi = c.dac;
                    q_next.be = nbe;
                    q_next.cmd = 2'b00;
                    q_next.wdata = npk;
                    q_next.st = psd_pkg::PSD_WR;
                end else if (so == 2'b11) begin
                    rd_a = {src[31:2] + 30'h0000_0001, 2'b00};
                    go_rd = 1'b1;
                end
            end
            psd_pkg::PSD_WR: begin
                if (q_reg.req && mem_ack_in) begin
                    q_next.req = 1'b0;
                    q_next.we = 1'b0;
                    q_next.pbe = 4'h0;
                    q_next.pack = `PSD_RESET_WORD;
                    if (c.cnt == 24'h00_0000) begin
                        fin = 1'b1;
                    end else if (so == 2'b00) begin
                        go_rd = 1'b1;
                    end else begin
                        q_next.st = psd_pkg::PSD_SHIFT;
                    end
                end
            end
        endcase

        if (go_rd) begin
            q_next.req = 1'b1;
            q_next.we = 1'b0;
            q_next.space = c.dir;
            q_next.addr = rd_a;
            // A fetch may load the upper address in this very cycle.
            q_next.addr_hi = q_next.ch[q_reg.cur].dac;
            q_next.be = 4'hf;
            q_next.cmd = c.rtype;
            q_next.st = psd_pkg::PSD_RD;
        end
        if (fin) begin
            q_next.ch[q_reg.cur].done = 1'b1;
            if (c.eoc) begin
                q_next.ch[q_reg.cur].cdone = 1'b1;
                q_next.ch[q_reg.cur].en = 1'b0;
                q_next.st = psd_pkg::PSD_IDLE;
            end else begin
                q_next.desc = q_next.ch[q_reg.cur].ptr;
                q_next.idx = 2'b00;
                go_fetch = 1'b1;
            end
        end
        if (go_fetch) begin
            q_next.req = 1'b1;
            q_next.we = 1'b0;
            q_next.space = 1'b0;
            q_next.addr = q_next.desc + {28'h000_0000, q_next.idx, 2'b00};
            q_next.be = 4'hf;
            q_next.cmd = 2'b00;
            q_next.st = psd_pkg::PSD_FETCH;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            q_reg <= '0;
            q_reg.st <= psd_pkg::PSD_IDLE;
        end else if (ce_in) begin
            q_reg <= q_next;
        end
    end

    assign rdata_out = q_reg.rdata;
    assign mem_req_out = q_reg.req;
    assign mem_we_out = q_reg.we;
    assign mem_space_out = q_reg.space;
    assign mem_addr_out = q_reg.addr;
    assign mem_addr_hi_out = q_reg.addr_hi;
    assign mem_be_out = q_reg.be;
    assign mem_cmd_out = q_reg.cmd;
    assign mem_wdata_out = q_reg.wdata;

    ////////////////////////////////////////////////////////////////////////

    read_all_lanes_a: assert property (@(posedge clk_in) disable iff (srst_in)
        mem_req_out && !mem_we_out |-> mem_be_out == 4'hf)
        else $error("read issued with masked byte lanes");

    pci_read_cmd_a: assert property (@(posedge clk_in) disable iff (srst_in)
        q_reg.st == psd_pkg::PSD_RD && mem_space_out
        |-> mem_cmd_out == q_reg.ch[q_reg.cur].rtype)
        else $error("PCI read command differs from read type field");

    fetch_ascending_a: assert property (@(posedge clk_in) disable iff (srst_in)
        q_reg.st == psd_pkg::PSD_FETCH && mem_req_out
        |-> mem_addr_out == q_reg.desc + {28'h000_0000, q_reg.idx, 2'b00}
            && !mem_space_out)
        else $error("descriptor word fetched out of order");

    upper_load_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && q_reg.st == psd_pkg::PSD_FETCH && mem_ack_in && mem_req_out
        && q_reg.idx == 2'b11 && q_reg.ch[q_reg.cur].sd[31]
        |=> q_reg.ch[q_reg.cur].dac == $past(mem_rdata_in)
            && q_reg.ch[q_reg.cur].ptr == $past(q_reg.desc) + 32'h0000_0010
            && (!mem_space_out || mem_addr_hi_out == $past(mem_rdata_in)))
        else $error("upper address or next pointer not loaded");

    upper_kept_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && q_reg.st == psd_pkg::PSD_FETCH && mem_ack_in && mem_req_out
        && q_reg.idx == 2'b11 && !q_reg.ch[q_reg.cur].sd[31] && !wr_in
        |=> q_reg.ch[q_reg.cur].dac == $past(q_reg.ch[q_reg.cur].dac)
            && q_reg.ch[q_reg.cur].ptr == $past(mem_rdata_in))
        else $error("upper address changed in pointer mode");

    write_aligned_a: assert property (@(posedge clk_in) disable iff (srst_in)
        mem_req_out && mem_we_out |-> mem_addr_out[1:0] == 2'b00
            && mem_be_out != 4'h0)
        else $error("write not Dword aligned or empty");

    skip_fetch_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && q_reg.st == psd_pkg::PSD_IDLE && q_reg.ch[q_reg.cur].en
        && q_reg.ch[q_reg.cur].init && q_reg.ch[q_reg.cur].cnt != 24'h00_0000
        |=> q_reg.st == psd_pkg::PSD_RD && mem_req_out)
        else $error("preloaded descriptor was fetched again");

    chain_stop_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && q_reg.st == psd_pkg::PSD_WR && mem_ack_in && mem_req_out
        && q_reg.ch[q_reg.cur].cnt == 24'h00_0000 && q_reg.ch[q_reg.cur].eoc
        |=> q_reg.ch[q_reg.cur].cdone && q_reg.ch[q_reg.cur].done
            && !q_reg.ch[q_reg.cur].en && q_reg.st == psd_pkg::PSD_IDLE)
        else $error("chain end did not set done flags and stop");

endmodule : psd_dma
`default_nettype wire

// >>> logic/psd_dma_regs.svh
// Register offsets, field positions and reset values of the DMA engine.
`ifndef PSD_DMA_REGS_SVH
`define PSD_DMA_REGS_SVH

`define PSD_OFF_CTRL   5'h00
`define PSD_OFF_COUNT  5'h04
`define PSD_OFF_PCI    5'h08
`define PSD_OFF_SDRAM  5'h0c
`define PSD_OFF_PTR    5'h10
`define PSD_OFF_DAC    5'h14

`define PSD_CTRL_EN      0
`define PSD_CTRL_DONE    2
`define PSD_CTRL_INIT    4
`define PSD_CTRL_RT_LO   5
`define PSD_CTRL_RT_HI   6
`define PSD_CTRL_CHDONE  7

`define PSD_CNT_EOC      31
`define PSD_CNT_DIR      30
`define PSD_CNT_MSB      23
`define PSD_MODE_BIT     31

`define PSD_DESC_STEP    32'h0000_0010
`define PSD_RESET_WORD   32'h0000_0000

`endif

// >>> logic/psd_pkg.sv
// Types of the two-channel descriptor DMA engine.
package psd_pkg;

    typedef enum logic [4:0] {
        PSD_IDLE  = 5'h01,
        PSD_FETCH = 5'h02,
        PSD_RD    = 5'h04,
        PSD_SHIFT = 5'h08,
        PSD_WR    = 5'h10
    } psd_state_t;

    typedef struct packed {
        logic        en;
        logic        init;
        logic [1:0]  rtype;
        logic        done;
        logic        cdone;
        logic        eoc;
        logic        dir;
        logic [23:0] cnt;
        logic [31:0] pci;
        logic [31:0] sd;
        logic [31:0] ptr;
        logic [31:0] dac;
    } psd_ch_t;

    typedef struct packed {
        psd_ch_t [1:0] ch;
        psd_state_t    st;
        logic          cur;
        logic [1:0]    idx;
        logic [31:0]   desc;
        logic [31:0]   word;
        logic [31:0]   pack;
        logic [3:0]    pbe;
        logic [31:0]   waddr;
        logic          req;
        logic          we;
        logic          space;
        logic [31:0]   addr;
        logic [31:0]   addr_hi;
        logic [3:0]    be;
        logic [1:0]    cmd;
        logic [31:0]   wdata;
        logic [31:0]   rdata;
    } psd_q_t;

endpackage : psd_pkg

// >>> verif/psd_mem_mdl.sv
// Far-side model: local SDRAM and PCI memory answering the engine's port.
`timescale 1ns/1ns
`default_nettype none

module psd_mem_mdl (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic [3:0]  lat_in,
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic        space_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [31:0] addr_hi_in,
    input  wire logic [3:0]  be_in,
    input  wire logic [1:0]  cmd_in,
    input  wire logic [31:0] wdata_in,
    output logic             ack_out,
    output logic      [31:0] rdata_out
);
    logic [7:0]  smem [16384];
    logic [7:0]  pmem [16384];
    logic [33:0] log_q [$];
    logic [3:0]  wbe_q [$];
    logic [1:0]  cmd_last;
    logic [31:0] hi_last;
    int          bad_be;
    logic [3:0]  wait_cnt;
    logic [13:0] a;

    initial begin
        for (int i = 0; i < 16384; i++) begin
            smem[i] = i[7:0] + 8'h33;
            pmem[i] = i[7:0] ^ 8'h5a;
        end
        bad_be = 0;
        ack_out = 1'b0;
        rdata_out = 32'h0000_0000;
        wait_cnt = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outside an answer the read data changes every cycle, so a stale
    // sample by the engine shows up as corrupted data.
    always @(posedge clk_in) begin
        a = {addr_in[13:2], 2'b00};
        if (srst_in || ack_out) begin
            ack_out <= 1'b0;
            wait_cnt <= 4'h0;
            rdata_out <= ~rdata_out;
        end else if (req_in && wait_cnt >= lat_in) begin
            ack_out <= 1'b1;
            log_q.push_back({we_in, space_in, addr_in});
            if (space_in) hi_last <= addr_hi_in;
            if (we_in) begin
                wbe_q.push_back(be_in);
                for (int i = 0; i < 4; i++) begin
                    if (be_in[i] && space_in) pmem[a + 14'(i)] = wdata_in[8*i+:8];
                    if (be_in[i] && !space_in) smem[a + 14'(i)] = wdata_in[8*i+:8];
                end
            end else begin
                if (be_in !== 4'hf) bad_be++;
                if (space_in) cmd_last <= cmd_in;
                for (int i = 0; i < 4; i++) begin
                    rdata_out[8*i+:8] <= space_in ? pmem[a + 14'(i)]
                                                  : smem[a + 14'(i)];
                end
            end
        end else begin
            wait_cnt <= wait_cnt + {3'b000, req_in};
            rdata_out <= ~rdata_out;
        end
    end
endmodule : psd_mem_mdl

`default_nettype wire

// >>> verif/tb_psd_dma.sv
// Self-checking testbench of the two-channel descriptor DMA engine.
`timescale 1ns/1ns
`default_nettype none
`include "psd_dma_regs.svh"

module tb_psd_dma;
    logic        clk_in, srst_in, ce_in, wr_in, rd_in;
    logic [7:0]  addr_in;
    logic [31:0] wdata_in, rdata_out, m_addr, m_hi, m_wdata, m_rdata;
    logic        m_req, m_we, m_space, m_ack;
    logic [3:0]  m_be, lat;
    logic [1:0]  m_cmd;
    int          miscompares, checked;
    logic [31:0] v, src, dst, e, g;
    logic [7:0]  g0, g1;
    logic        dir;
    int          s, d, n, last, hits;

    psd_dma dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .mem_req_out(m_req), .mem_we_out(m_we),
        .mem_space_out(m_space), .mem_addr_out(m_addr),
        .mem_addr_hi_out(m_hi), .mem_be_out(m_be), .mem_cmd_out(m_cmd),
        .mem_wdata_out(m_wdata), .mem_ack_in(m_ack), .mem_rdata_in(m_rdata));

    psd_mem_mdl mdl (.clk_in(clk_in), .srst_in(srst_in), .lat_in(lat),
        .req_in(m_req), .we_in(m_we), .space_in(m_space), .addr_in(m_addr),
        .addr_hi_in(m_hi), .be_in(m_be), .cmd_in(m_cmd), .wdata_in(m_wdata),
        .ack_out(m_ack), .rdata_out(m_rdata));

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic chk_be(input string nm, input logic [3:0] ex,
                          input logic [3:0] got);
        checked++;
        if (got !== ex) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", nm, ex, got);
        end
    endtask : chk_be

    function automatic logic [7:0] ra(input int ch, input logic [4:0] off);
        return {2'b00, ch[0], off};
    endfunction : ra

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= dat;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] val);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        val = rdata_out;
    endtask : rd

    task automatic wait_done(input int ch);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; r[7] !== 1'b1; i++) begin
            if (i == 400) begin
                miscompares++;
                $display("MISMATCH chain_done expected 1 seen 0");
                end_sim();
            end
            rd(ra(ch, `PSD_OFF_CTRL), r);
        end
    endtask : wait_done

    task automatic put(input int a, input logic [31:0] w);
        for (int i = 0; i < 4; i++) mdl.smem[a + i] = w[8*i+:8];
    endtask : put

    ////////////////////////////////////////////////////////////////////////
    initial begin
        srst_in = 1'b1;
        ce_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h0000_0000;
        lat = 4'h0;
        miscompares = 0;
        checked = 0;
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;

        for (int k = 0; k < 12; k++) begin
            rd(ra(k / 6, 5'(4 * (k % 6))), v);
            chk("reset_value", 32'h0000_0000, v);
        end
        wr(ra(0, `PSD_OFF_PTR), 32'h0000_1230);
        wr(8'h90, 32'h0000_ffff);
        rd(ra(0, `PSD_OFF_PTR), v);
        chk("ptr_value", 32'h0000_1230, v);
        @(posedge clk_in);
        ce_in <= 1'b0;
        wr(ra(0, `PSD_OFF_PTR), 32'h0000_0bad);
        ce_in <= 1'b1;
        rd(ra(0, `PSD_OFF_PTR), v);
        chk("ptr_frozen", 32'h0000_1230, v);
        @(negedge clk_in);
        chk("rdata_idle", 32'h0000_0000, rdata_out);
        rd(8'h18, v);
        chk("unmapped_read", 32'h0000_0000, v);
        $display("Test registers done");

        for (int k = 0; k < 4; k++) begin
            s = 3 - k;
            d = k;
            n = 5 + k;
            dir = ~k[0];
            lat = 4'(k);
            src = dir ? 32'h100 + s : 32'h600 + s;
            dst = dir ? 32'h500 + d : 32'h700 + d;
            g0 = dir ? mdl.smem[dst - 1] : mdl.pmem[dst - 1];
            g1 = dir ? mdl.smem[dst + n] : mdl.pmem[dst + n];
            mdl.log_q.delete();
            mdl.wbe_q.delete();
            wr(ra(0, `PSD_OFF_DAC), 32'h0000_00a0 + k);
            wr(ra(0, `PSD_OFF_PCI), dir ? src : dst);
            wr(ra(0, `PSD_OFF_SDRAM), dir ? dst : src);
            wr(ra(0, `PSD_OFF_COUNT), {1'b1, dir, 6'h0, 24'(n)});
            wr(ra(0, `PSD_OFF_CTRL), {25'h0, 2'(k % 3), 5'h11});
            wait_done(0);
            for (int j = 0; j < n; j++) begin
                e = dir ? mdl.pmem[src + j] : mdl.smem[src + j];
                g = dir ? mdl.smem[dst + j] : mdl.pmem[dst + j];
                chk("data_byte", e, g);
            end
            e = dir ? mdl.smem[dst - 1] : mdl.pmem[dst - 1];
            chk("guard_low", g0, e);
            e = dir ? mdl.smem[dst + n] : mdl.pmem[dst + n];
            chk("guard_high", g1, e);
            chk_be("first_be", 4'hf << d, mdl.wbe_q[0]);
            last = (d + n - 1) % 4;
            chk_be("last_be", 4'((5'h02 << last) - 1), mdl.wbe_q[$]);
            if (dir) chk("pci_cmd", k % 3, mdl.cmd_last);
            chk("dac_out", 32'h0000_00a0 + k, mdl.hi_last);
            chk("first_access", {src[31:2], 1'b0, dir},
                {mdl.log_q[0][31:2], mdl.log_q[0][33:32]});
            rd(ra(0, `PSD_OFF_CTRL), v);
            chk("ctrl_flags", 32'h0000_0084, v & 32'h84);
            rd(ra(0, `PSD_OFF_COUNT), v);
            chk("count_left", 32'h0000_0000, {8'h0, v[23:0]});
            rd(ra(0, dir ? `PSD_OFF_PCI : `PSD_OFF_SDRAM), v);
            chk("src_addr", src + n, v);
            rd(ra(0, dir ? `PSD_OFF_SDRAM : `PSD_OFF_PCI), v);
            chk("dst_addr", dst + n, v);
            wr(ra(0, `PSD_OFF_CTRL), 32'h0000_0084);
            rd(ra(0, `PSD_OFF_CTRL), v);
            chk("ctrl_clear", 32'h0000_0000, v & 32'h84);
            $display("Test direct transfer %0d done", k);
        end
        chk("read_be_bad", 32'h0000_0000, mdl.bad_be);

        lat = 4'h2;
        mdl.log_q.delete();
        put(32'h200, 32'h4000_0005);
        put(32'h204, 32'h0000_1002);
        put(32'h208, 32'h8000_0300);
        put(32'h20c, 32'h0000_0005);
        put(32'h210, 32'hc000_0004);
        put(32'h214, 32'h0000_2001);
        put(32'h218, 32'h0000_0400);
        put(32'h21c, 32'h0000_0999);
        wr(ra(1, `PSD_OFF_DAC), 32'h0000_0077);
        wr(ra(1, `PSD_OFF_PTR), 32'h0000_0200);
        wr(ra(1, `PSD_OFF_CTRL), 32'h0000_0021);
        wait_done(1);
        for (int i = 0; i < 4; i++) begin
            chk("fetch_addr", 32'h200 + 4 * i, mdl.log_q[i][31:0]);
            chk("fetch_kind", 32'h0, 32'(mdl.log_q[i][33:32]));
        end
        hits = 0;
        foreach (mdl.log_q[i]) hits += (mdl.log_q[i] == 34'h0_0000_0210);
        chk("next_at_plus16", 32'h1, hits);
        for (int j = 0; j < 5; j++)
            chk("chain_byte1", mdl.pmem[32'h1002 + j],
                mdl.smem[32'h300 + j]);
        for (int j = 0; j < 4; j++)
            chk("chain_byte2", mdl.pmem[32'h2001 + j], mdl.smem[32'h400 + j]);
        rd(ra(1, `PSD_OFF_DAC), v);
        chk("dac_kept", 32'h0000_0005, v);
        rd(ra(1, `PSD_OFF_PTR), v);
        chk("ptr_loaded", 32'h0000_0999, v);
        chk("dac_out", 32'h0000_0005, mdl.hi_last);
        chk("pci_cmd", 32'h1, mdl.cmd_last);
        rd(ra(1, `PSD_OFF_CTRL), v);
        chk("ctrl_flags", 32'h0000_0084, v & 32'h84);
        rd(ra(0, `PSD_OFF_CTRL), v);
        chk("other_channel", 32'h0000_0000, v);
        $display("Test descriptor chain done");
        end_sim();
    end
endmodule : tb_psd_dma

`default_nettype wire
